/* File: core/hcs_config_select.sv */
// Hub configuration source selection, strap latch and configuration registers
`timescale 1ns/1ps
module hcs_config_select #(
	parameter int unsigned NUM_PORTS = hcs_pkg::NUM_PORTS,
	parameter int unsigned SETTLE_CYC = hcs_pkg::STRAP_SETTLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hcs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [hcs_pkg::SP_CHG_LSB+3*NUM_PORTS-1:0] strap_in,
	output logic [hcs_pkg::SP_CHG_LSB+3*NUM_PORTS-1:0] strap_out,
	output logic [hcs_pkg::SP_CHG_LSB+3*NUM_PORTS-1:0] strap_oe,
	input wire logic sda_in,
	input wire logic [hcs_pkg::SP_CHG_LSB+3*NUM_PORTS-1:0] func_out,
	input wire logic suspend_state,
	input wire logic hub_attached,
	input wire logic eeprom_load_done,
	output hcs_pkg::hcs_src_e cfg_source,
	output logic config_ready,
	output logic bus_powered,
	output logic eeprom_load_req,
	output logic [NUM_PORTS-1:0] fixed_ports,
	output logic susp_active_low,
	output logic [NUM_PORTS-1:0] port_charge_report,
	output logic [NUM_PORTS-1:0] port_disabled,
	output logic [1:0] charge_up_mode,
	output logic [1:0] charge_dn_mode,
	output logic [1:0] otp_mode,
	output logic vendor_hub_commands,
	output logic ec_enable,
	output logic special_resume,
	output logic hub_reset_pulse,
	output logic pass_valid,
	output logic [1:0] pass_op,
	output logic [7:0] pass_data
);

	localparam int unsigned DM_LSB = hcs_pkg::SP_CHG_LSB + NUM_PORTS;
	localparam int unsigned DP_LSB = DM_LSB + NUM_PORTS;
	localparam int unsigned STRAP_W = DP_LSB + NUM_PORTS;
	localparam int unsigned CNT_W = $clog2(SETTLE_CYC + 1);

	if (NUM_PORTS < hcs_pkg::FIXED_MAX_PORTS || NUM_PORTS > hcs_pkg::MAX_PORTS) begin : g_bad_ports
		$error("NUM_PORTS must lie between 3 and 8");
	end
	if (SETTLE_CYC < hcs_pkg::SYNC_STAGES + 1) begin : g_bad_settle
		$error("SETTLE_CYC must exceed the synchroniser depth");
	end

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [STRAP_W:0] strap_sync;
	logic [STRAP_W-1:0] strap_lat;
	logic sda_lat;
	logic latched;
	logic straps_used;
	logic [CNT_W-1:0] settle_cnt;
	logic settle_done;
	hcs_pkg::hcs_src_e next_src;
	hcs_pkg::hcs_state_e state;
	hcs_pkg::hcs_state_e next_state;
	logic [hcs_pkg::CTRL_W-1:0] ctrl;
	logic [hcs_pkg::CTRL_W-1:0] next_ctrl;
	logic [NUM_PORTS-1:0] fixed_reg;
	logic wr_go;
	logic [31:0] rd_data;
	logic rd_err;
	logic [1:0] sel_lat;
	logic [1:0] fix_lat;
	logic [NUM_PORTS-1:0] chg_lat;
	logic [NUM_PORTS-1:0] dm_lat;
	logic [NUM_PORTS-1:0] dp_lat;

	assign sel_lat = strap_lat[hcs_pkg::SP_SEL_LSB +: 2];
	assign fix_lat = strap_lat[hcs_pkg::SP_FIX_LSB +: 2];
	assign chg_lat = strap_lat[hcs_pkg::SP_CHG_LSB +: NUM_PORTS];
	assign dm_lat = strap_lat[DM_LSB +: NUM_PORTS];
	assign dp_lat = strap_lat[DP_LSB +: NUM_PORTS];

	function automatic hcs_pkg::hcs_src_e decode_src(input logic [1:0] sel, input logic sda);
		hcs_pkg::hcs_src_e src;
		src = hcs_pkg::SRC_INVALID;
		unique case (sel)
			hcs_pkg::SEL_SELF: src = hcs_pkg::SRC_SELF_PWR; // RULE1
			hcs_pkg::SEL_BUS: src = hcs_pkg::SRC_BUS_PWR; // RULE2
			hcs_pkg::SEL_EEPROM: src = sda ? hcs_pkg::SRC_EEPROM : hcs_pkg::SRC_INVALID; // RULE3
			hcs_pkg::SEL_SMBUS: src = sda ? hcs_pkg::SRC_SMBUS : hcs_pkg::SRC_INVALID; // RULE4
		endcase
		return src;
	endfunction : decode_src

	// Code n fixes ports 1..n
	function automatic logic [NUM_PORTS-1:0] fixed_mask(input logic [1:0] code);
		return NUM_PORTS'((1 << code) - 1);
	endfunction : fixed_mask

	// ----------------------------------------
	// Strap capture after reset release
	// ----------------------------------------
	hcs_sync #(
		.W(STRAP_W + 1)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({sda_in, strap_in}),
		.q(strap_sync)
	);

	// The wait lets the pins settle and flush the synchroniser before capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_cnt <= '0;
		end else if (ce && !latched) begin
			settle_cnt <= settle_cnt + CNT_W'(1);
		end
	end

	assign settle_done = !latched && (settle_cnt == CNT_W'(SETTLE_CYC - 1));
	assign next_src = decode_src(strap_sync[hcs_pkg::SP_SEL_LSB +: 2], strap_sync[STRAP_W]);

	// Captured once, then frozen until the next reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched <= 1'b0;
			strap_lat <= '0;
			sda_lat <= 1'b0;
			cfg_source <= hcs_pkg::SRC_SELF_PWR;
			straps_used <= 1'b0;
			bus_powered <= 1'b0;
		end else if (ce && settle_done) begin
			latched <= 1'b1; // RULE17
			strap_lat <= strap_sync[STRAP_W-1:0]; // RULE12
			sda_lat <= strap_sync[STRAP_W];
			cfg_source <= next_src;
			straps_used <= (next_src == hcs_pkg::SRC_SELF_PWR)
				|| (next_src == hcs_pkg::SRC_BUS_PWR); // RULE3 RULE4
			bus_powered <= (next_src == hcs_pkg::SRC_BUS_PWR); // RULE2
		end
	end

	// Pins stay released until the capture is done, then carry their functions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_oe <= '0;
			strap_out <= '0;
		end else if (ce) begin
			strap_oe <= {STRAP_W{latched}}; // RULE11
			strap_out <= func_out;
			strap_out[hcs_pkg::SP_FIX_LSB] <= suspend_state ^ susp_active_low; // RULE13
		end
	end

	// ----------------------------------------
	// Configuration load sequence
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			hcs_pkg::ST_SETTLE: begin
				if (settle_done) begin
					unique case (next_src)
						hcs_pkg::SRC_SELF_PWR: next_state = hcs_pkg::ST_READY; // RULE1
						hcs_pkg::SRC_BUS_PWR: next_state = hcs_pkg::ST_READY; // RULE2
						hcs_pkg::SRC_EEPROM: next_state = hcs_pkg::ST_EEPROM; // RULE3
						hcs_pkg::SRC_SMBUS: next_state = hcs_pkg::ST_SMBUS; // RULE4
						hcs_pkg::SRC_INVALID: next_state = hcs_pkg::ST_INVALID;
					endcase
				end
			end
			hcs_pkg::ST_EEPROM: begin
				if (eeprom_load_done) begin
					next_state = hcs_pkg::ST_READY;
				end
			end
			hcs_pkg::ST_SMBUS: begin
				if (ctrl[hcs_pkg::CTRL_CFG_DONE]) begin
					next_state = hcs_pkg::ST_READY; // RULE4
				end
			end
			hcs_pkg::ST_READY: next_state = hcs_pkg::ST_READY;
			hcs_pkg::ST_INVALID: next_state = hcs_pkg::ST_INVALID;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= hcs_pkg::ST_SETTLE;
			config_ready <= 1'b0;
			eeprom_load_req <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			config_ready <= (next_state == hcs_pkg::ST_READY);
			eeprom_load_req <= (next_state == hcs_pkg::ST_EEPROM); // RULE3
		end
	end

	// ----------------------------------------
	// Feature outputs
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fixed_ports <= '0;
			susp_active_low <= 1'b0;
			port_charge_report <= '0;
			port_disabled <= '0;
			otp_mode <= hcs_pkg::OTP_SINGLE;
		end else if (ce) begin
			if (ctrl[hcs_pkg::CTRL_LOCAL_POWER_DETECT]) begin
				fixed_ports <= fixed_reg; // RULE14
			end else begin
				fixed_ports <= straps_used ? fixed_mask(fix_lat) : '0; // RULE13
			end
			susp_active_low <= straps_used && fix_lat[0]; // RULE13
			if (ctrl[hcs_pkg::CTRL_CHG_OVR]) begin
				port_charge_report <= {NUM_PORTS{ctrl[hcs_pkg::CTRL_CHG_EN]}}; // RULE9
			end else begin
				port_charge_report <= straps_used ? chg_lat : '0; // RULE15
			end
			port_disabled <= straps_used ? (dm_lat & dp_lat) : '0; // RULE16
			if (ctrl[hcs_pkg::CTRL_OTP_USB]) begin
				otp_mode <= hcs_pkg::OTP_SINGLE; // RULE7
			end else begin
				otp_mode <= ctrl[hcs_pkg::CTRL_OTP_LSB +: 2]; // RULE8
			end
		end
	end

	assign charge_up_mode = ctrl[hcs_pkg::CTRL_UP_LSB +: 2];
	assign charge_dn_mode = ctrl[hcs_pkg::CTRL_DN_LSB +: 2];
	assign vendor_hub_commands = ctrl[hcs_pkg::CTRL_VENDOR_EN];

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	assign wr_go = psel && penable && pready && pwrite;

	// Attached hub keeps its locked configuration bits
	assign next_ctrl = hub_attached
		? ((pwdata[hcs_pkg::CTRL_W-1:0] & ~hcs_pkg::CTRL_LOCK_MASK)
			| (ctrl & hcs_pkg::CTRL_LOCK_MASK))
		: pwdata[hcs_pkg::CTRL_W-1:0]; // RULE10

	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		case (paddr)
			hcs_pkg::OFS_STATUS: begin
				rd_data[hcs_pkg::ST_SRC_LSB +: 3] = cfg_source;
				rd_data[hcs_pkg::ST_CFG_RDY] = config_ready;
				rd_data[hcs_pkg::ST_ATTACHED] = hub_attached;
				rd_data[hcs_pkg::ST_SUSP_LOW] = susp_active_low;
				rd_data[hcs_pkg::ST_SEL_LSB +: 2] = sel_lat;
				rd_data[hcs_pkg::ST_SDA] = sda_lat;
				rd_data[hcs_pkg::ST_LATCHED] = latched;
			end
			hcs_pkg::OFS_PORTS: begin
				rd_data[hcs_pkg::PR_CHG_LSB +: NUM_PORTS] = port_charge_report;
				rd_data[hcs_pkg::PR_DIS_LSB +: NUM_PORTS] = port_disabled;
				rd_data[hcs_pkg::PR_FIX_LSB +: NUM_PORTS] = fixed_ports;
			end
			hcs_pkg::OFS_CTRL: rd_data[hcs_pkg::CTRL_W-1:0] = ctrl;
			hcs_pkg::OFS_FIXED: begin
				rd_data[NUM_PORTS-1:0] = fixed_reg;
				rd_err = pwrite && hub_attached; // RULE10
			end
			hcs_pkg::OFS_CMD: rd_data = '0;
			default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && rd_err;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_data;
			end
		end
	end

	// ----------------------------------------
	// Registers written by software, and commands
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= hcs_pkg::CTRL_RESET; // RULE5
			fixed_reg <= '0;
		end else if (ce && wr_go) begin
			if (paddr == hcs_pkg::OFS_CTRL) begin
				ctrl <= next_ctrl;
			end
			if (paddr == hcs_pkg::OFS_FIXED && !hub_attached) begin
				fixed_reg <= pwdata[NUM_PORTS-1:0]; // RULE10 RULE14
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ec_enable <= 1'b0;
			special_resume <= 1'b0;
			hub_reset_pulse <= 1'b0;
		end else if (ce) begin
			hub_reset_pulse <= 1'b0;
			if (wr_go && paddr == hcs_pkg::OFS_CMD && pwdata[hcs_pkg::CMD_VND_GO]
				&& ctrl[hcs_pkg::CTRL_VENDOR_EN]) begin
				case (pwdata[hcs_pkg::CMD_VND_LSB +: 3]) // RULE5
					hcs_pkg::VND_EC_ON: ec_enable <= 1'b1;
					hcs_pkg::VND_EC_OFF: ec_enable <= 1'b0;
					hcs_pkg::VND_RESUME_ON: special_resume <= 1'b1;
					hcs_pkg::VND_RESUME_OFF: special_resume <= 1'b0;
					hcs_pkg::VND_HUB_RESET: hub_reset_pulse <= 1'b1;
					default: hub_reset_pulse <= 1'b0;
				endcase
			end
		end
	end

	// Pass-through is forwarded raw; the far device decides what it means
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pass_valid <= 1'b0;
			pass_op <= hcs_pkg::PASS_WRITE;
			pass_data <= '0;
		end else if (ce) begin
			pass_valid <= wr_go && paddr == hcs_pkg::OFS_CMD
				&& pwdata[hcs_pkg::CMD_PASS_GO] && ctrl[hcs_pkg::CTRL_PASS_EN]; // RULE6
			if (wr_go && paddr == hcs_pkg::OFS_CMD && pwdata[hcs_pkg::CMD_PASS_GO]) begin
				pass_op <= pwdata[hcs_pkg::CMD_PASS_LSB +: 2]; // RULE6
				pass_data <= pwdata[hcs_pkg::CMD_DATA_LSB +: 8];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	sequence s_latch;
		$rose(latched);
	endsequence

	sequence s_cmd_write;
		wr_go && paddr == hcs_pkg::OFS_CMD;
	endsequence

	property p_self;
		s_latch ##0 (sel_lat == hcs_pkg::SEL_SELF)
			|-> cfg_source == hcs_pkg::SRC_SELF_PWR && !bus_powered && config_ready;
	endproperty
	a_self: assert property (p_self) else $error("self-powered selection wrong"); // RULE1

	property p_bus;
		s_latch ##0 (sel_lat == hcs_pkg::SEL_BUS)
			|-> cfg_source == hcs_pkg::SRC_BUS_PWR && bus_powered && straps_used;
	endproperty
	a_bus: assert property (p_bus) else $error("bus-powered selection wrong"); // RULE2

	property p_eeprom;
		s_latch ##0 (sel_lat == hcs_pkg::SEL_EEPROM && sda_lat)
			|-> eeprom_load_req && !straps_used ##1 port_disabled == '0;
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("EEPROM load not requested"); // RULE3

	property p_smbus_wait;
		state == hcs_pkg::ST_SMBUS && !ctrl[hcs_pkg::CTRL_CFG_DONE] |=> !config_ready;
	endproperty
	a_smbus_wait: assert property (p_smbus_wait) else $error("ready before SMBus done"); // RULE4

	property p_vendor;
		s_cmd_write ##0 (pwdata[hcs_pkg::CMD_VND_GO] && ctrl[hcs_pkg::CTRL_VENDOR_EN]
			&& pwdata[hcs_pkg::CMD_VND_LSB +: 3] == hcs_pkg::VND_HUB_RESET)
			|=> hub_reset_pulse ##1 !hub_reset_pulse;
	endproperty
	a_vendor: assert property (p_vendor) else $error("hub reset command lost"); // RULE5

	property p_pass;
		s_cmd_write ##0 (pwdata[hcs_pkg::CMD_PASS_GO] && ctrl[hcs_pkg::CTRL_PASS_EN])
			|=> pass_valid && pass_op == $past(pwdata[hcs_pkg::CMD_PASS_LSB +: 2]);
	endproperty
	a_pass: assert property (p_pass) else $error("pass-through command not forwarded"); // RULE6

	property p_otp_usb;
		ctrl[hcs_pkg::CTRL_OTP_USB] |=> otp_mode == hcs_pkg::OTP_SINGLE;
	endproperty
	a_otp_usb: assert property (p_otp_usb) else $error("USB OTP not single-ended"); // RULE7

	property p_otp_smbus;
		!ctrl[hcs_pkg::CTRL_OTP_USB] |=> otp_mode == $past(ctrl[hcs_pkg::CTRL_OTP_LSB +: 2]);
	endproperty
	a_otp_smbus: assert property (p_otp_smbus) else $error("OTP mode not applied"); // RULE8

	property p_charge_ovr;
		ctrl[hcs_pkg::CTRL_CHG_OVR]
			|=> port_charge_report == {NUM_PORTS{$past(ctrl[hcs_pkg::CTRL_CHG_EN])}};
	endproperty
	a_charge_ovr: assert property (p_charge_ovr) else $error("charging override ignored"); // RULE9

	property p_lock;
		wr_go && paddr == hcs_pkg::OFS_FIXED && hub_attached |-> pslverr ##1 $stable(fixed_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("write accepted after attach"); // RULE10

	property p_tristate;
		(!latched |-> strap_oe == '0) and (s_latch |=> strap_oe == '1);
	endproperty
	a_tristate: assert property (p_tristate) else $error("strap pin drive wrong"); // RULE11

	property p_capture;
		s_latch |-> strap_lat == $past(strap_sync[STRAP_W-1:0]);
	endproperty
	a_capture: assert property (p_capture) else $error("strap capture wrong"); // RULE12

	property p_fixed;
		straps_used && !ctrl[hcs_pkg::CTRL_LOCAL_POWER_DETECT]
			|=> fixed_ports == fixed_mask($past(fix_lat)) && susp_active_low == $past(fix_lat[0]);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed-port decode wrong"); // RULE13

	property p_local_power_detect;
		ctrl[hcs_pkg::CTRL_LOCAL_POWER_DETECT] |=> fixed_ports == $past(fixed_reg);
	endproperty
	a_local_power_detect: assert property (p_local_power_detect) else $error("local power source wrong"); // RULE14

	property p_charge_strap;
		straps_used && !ctrl[hcs_pkg::CTRL_CHG_OVR] |=> port_charge_report == $past(chg_lat);
	endproperty
	a_charge_strap: assert property (p_charge_strap) else $error("charge strap ignored"); // RULE15

	property p_disable;
		straps_used |=> port_disabled == ($past(dm_lat) & $past(dp_lat));
	endproperty
	a_disable: assert property (p_disable) else $error("port disable decode wrong"); // RULE16

	property p_hold;
		latched |=> latched && $stable(strap_lat) && $stable(cfg_source);
	endproperty
	a_hold: assert property (p_hold) else $error("latched straps changed"); // RULE17

endmodule : hcs_config_select

/* File: core/hcs_sync.sv */
// Two-stage synchroniser for pin levels entering the pclk domain
`timescale 1ns/1ps
module hcs_sync #(
	parameter int unsigned W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : hcs_sync

/* File: include/hcs_pkg.sv */
// Constants, types and register map of the hub configuration selector and strap latch
// Function
// [RULE1] Selects 00: straps plus OTP, self-powered
// [RULE2] Selects 10: straps plus OTP, bus-powered
// [RULE3] Selects 11, data high: EEPROM load, straps ignored
// [RULE4] Selects 01, data high: await SMBus; data low invalid
// [RULE5] Vendor hub commands accepted by default
// [RULE6] Serial pass-through commands forwarded uninterpreted
// [RULE7] OTP reached from USB runs single-ended
// [RULE8] OTP over SMBus takes any of four modes
// [RULE9] Host may override charging behaviour at run time
// [RULE10] Configuration writes accepted only before hub attach; after attach the code still writes the control bits outside CTRL_LOCK_MASK
// [RULE11] Strap pins tri-stated in reset, outputs afterwards
// [RULE12] Strap levels captured at reset release
// [RULE13] Fixed-port strap sets fixed ports and indicator polarity
// [RULE14] Local power detect takes fixed ports from register
// [RULE15] Charge-enable strap high makes port report charging
// [RULE16] Port disabled only when both line straps high
// [RULE17] Latched straps held until next reset
package hcs_pkg;

	// ----------------------------------------
	// Sizes and timing
	// ----------------------------------------
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned MAX_PORTS = 8;
	localparam int unsigned FIXED_MAX_PORTS = 3;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned CLK_PERIOD_NS = 40;
	// Least time the strap levels need after release before they are trusted
	localparam int unsigned STRAP_SETTLE_NS = 200;
	localparam int unsigned STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Strap vector layout (per-port groups follow the charge group)
	// ----------------------------------------
	localparam int unsigned SP_SEL_LSB = 0;
	localparam int unsigned SP_FIX_LSB = 2;
	localparam int unsigned SP_CHG_LSB = 4;

	localparam logic [1:0] SEL_SELF = 2'h0;
	localparam logic [1:0] SEL_SMBUS = 2'h1;
	localparam logic [1:0] SEL_BUS = 2'h2;
	localparam logic [1:0] SEL_EEPROM = 2'h3;

	// ----------------------------------------
	// APB register map
	// ----------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_PORTS = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_FIXED = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;

	localparam int unsigned ST_SRC_LSB = 0;
	localparam int unsigned ST_CFG_RDY = 3;
	localparam int unsigned ST_ATTACHED = 4;
	localparam int unsigned ST_SUSP_LOW = 5;
	localparam int unsigned ST_SEL_LSB = 6;
	localparam int unsigned ST_SDA = 8;
	localparam int unsigned ST_LATCHED = 9;

	localparam int unsigned PR_CHG_LSB = 0;
	localparam int unsigned PR_DIS_LSB = 8;
	localparam int unsigned PR_FIX_LSB = 16;

	localparam int unsigned CTRL_W = 13;
	localparam int unsigned CTRL_LOCAL_POWER_DETECT = 0;
	localparam int unsigned CTRL_VENDOR_EN = 1;
	localparam int unsigned CTRL_PASS_EN = 2;
	localparam int unsigned CTRL_OTP_USB = 3;
	localparam int unsigned CTRL_OTP_LSB = 4;
	localparam int unsigned CTRL_CHG_OVR = 6;
	localparam int unsigned CTRL_CHG_EN = 7;
	localparam int unsigned CTRL_UP_LSB = 8;
	localparam int unsigned CTRL_DN_LSB = 10;
	localparam int unsigned CTRL_CFG_DONE = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0002;
	// Bits frozen once the hub has attached upstream
	localparam logic [CTRL_W-1:0] CTRL_LOCK_MASK = 13'h1001;

	localparam int unsigned CMD_VND_LSB = 0;
	localparam int unsigned CMD_VND_GO = 3;
	localparam int unsigned CMD_PASS_LSB = 4;
	localparam int unsigned CMD_PASS_GO = 6;
	localparam int unsigned CMD_DATA_LSB = 8;

	// ----------------------------------------
	// Command and mode codes
	// ----------------------------------------
	localparam logic [2:0] VND_EC_ON = 3'h0;
	localparam logic [2:0] VND_EC_OFF = 3'h1;
	localparam logic [2:0] VND_RESUME_ON = 3'h2;
	localparam logic [2:0] VND_RESUME_OFF = 3'h3;
	localparam logic [2:0] VND_HUB_RESET = 3'h4;

	localparam logic [1:0] PASS_WRITE = 2'h0;
	localparam logic [1:0] PASS_READ = 2'h1;
	localparam logic [1:0] PASS_START = 2'h2;
	localparam logic [1:0] PASS_STOP = 2'h3;

	localparam logic [1:0] OTP_SINGLE = 2'h0;
	localparam logic [1:0] OTP_DIFF = 2'h1;
	localparam logic [1:0] OTP_REDUN = 2'h2;
	localparam logic [1:0] OTP_DIFF_REDUN = 2'h3;

	typedef enum logic [2:0] {
		SRC_SELF_PWR,
		SRC_BUS_PWR,
		SRC_EEPROM,
		SRC_SMBUS,
		SRC_INVALID
	} hcs_src_e;

	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_EEPROM,
		ST_SMBUS,
		ST_READY,
		ST_INVALID
	} hcs_state_e;

endpackage : hcs_pkg

/* File: verif/hcs_board.sv */
// Board strap resistors and serial data pull seen by the strap pins
`timescale 1ns/1ps
module hcs_board #(
	parameter int unsigned W = 16
) (
	input wire logic [W-1:0] pattern,
	input wire logic sda_level,
	input wire logic [W-1:0] strap_out,
	input wire logic [W-1:0] strap_oe,
	output logic [W-1:0] strap_in,
	output logic sda_in
);
	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	// Resistors hold each level until the device drives the pin itself
	assign strap_in = (strap_oe & strap_out) | (~strap_oe & pattern);
	assign sda_in = sda_level;
endmodule : hcs_board

/* File: verif/hub_config_select_and_straps_tb_top.sv */
// Self-checking bench of the configuration selector and strap latch
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module hub_config_select_and_straps_tb_top;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, sda = 1, pready;
	logic pslverr, suspend_state = 0, hub_attached = 0, eeprom_load_done = 0, sda_in;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] strap_in, strap_out, strap_oe, pattern = 0, func_out = 16'hA5A5;
	logic [3:0] fixed_ports, port_charge_report, port_disabled;
	logic [1:0] charge_up_mode, charge_dn_mode, otp_mode, pass_op;
	logic [7:0] pass_data;
	logic config_ready, bus_powered, eeprom_load_req, susp_active_low, ec_enable, pass_valid, e;
	logic special_resume, hub_reset_pulse, vendor_hub_commands;
	hcs_pkg::hcs_src_e cfg_source;
	int err_count = 0, n_tests = 0, cyc = 0;
	always #20 pclk = ~pclk;
	hcs_config_select #(.SETTLE_CYC(3)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .strap_in, .strap_out, .strap_oe, .sda_in,
		.func_out, .suspend_state, .hub_attached, .eeprom_load_done, .cfg_source, .config_ready,
		.bus_powered, .eeprom_load_req, .fixed_ports, .susp_active_low, .port_charge_report,
		.port_disabled, .charge_up_mode, .charge_dn_mode, .otp_mode, .vendor_hub_commands,
		.ec_enable, .special_resume, .hub_reset_pulse, .pass_valid, .pass_op, .pass_data);
	hcs_board #(.W(16)) board (.pattern, .sda_level(sda), .strap_out, .strap_oe, .strap_in,
		.sda_in);
	// ----------------------------------------
	// Bus, reset, selection case and verdict tasks
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, penable} <= {1'b1, w, a, d, 1'b0};
		@(posedge pclk);
		penable <= 1;
		// Only the bench timeout ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rst_cycle;
		presetn <= 0;
		repeat (5) @(posedge pclk);
		`CHK(strap_oe, 16'h0)
		presetn <= 1;
		repeat (8) @(posedge pclk);
	endtask : rst_cycle
	task run_case(input logic s, input logic [1:0] sel, fix, input logic [2:0] src,
		input logic [3:0] fx);
		{sda, pattern} <= {s, 12'h0, fix, sel};
		rst_cycle;
		`CHK(cfg_source, src)
		`CHK(config_ready, src < 3'd2)
		`CHK(fixed_ports, fx)
		`CHK(susp_active_low, src < 3'd2 && fix[0])
		if (src == 3'd2) begin
			`CHK(eeprom_load_req, 1'b1)
			eeprom_load_done <= 1;
			repeat (3) @(posedge pclk);
			eeprom_load_done <= 0;
			`CHK(config_ready, 1'b1)
		end
		if (src == 3'd3) begin
			apb(1, hcs_pkg::OFS_CTRL, 32'h1002);
			repeat (3) @(posedge pclk);
			`CHK(config_ready, 1'b1)
		end
		$display("selection case %0d done", src);
	endtask : run_case
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Long enough for every case with a wide margin
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		pattern <= 16'h53A6;
		rst_cycle;
		`CHK(bus_powered, 1'b1)
		`CHK(fixed_ports, 4'h1)
		`CHK(susp_active_low, 1'b1)
		`CHK(port_charge_report, 4'hA)
		`CHK(port_disabled, 4'h1)
		`CHK(strap_oe, 16'hFFFF)
		apb(0, hcs_pkg::OFS_STATUS, 0);
		`CHK(rd, 32'h3A9)
		apb(0, hcs_pkg::OFS_PORTS, 0);
		`CHK(rd, 32'h0001010A)
		pattern <= 16'h0;
		repeat (4) @(posedge pclk);
		`CHK(fixed_ports, 4'h1)
		$display("strap latch test done");
		apb(1, hcs_pkg::OFS_CTRL, 32'h37);
		apb(1, hcs_pkg::OFS_FIXED, 32'hF);
		repeat (2) @(posedge pclk);
		`CHK(fixed_ports, 4'hF)
		`CHK(otp_mode, 2'h3)
		apb(1, hcs_pkg::OFS_CMD, 32'h8);
		repeat (2) @(posedge pclk);
		`CHK(ec_enable, 1'b1)
		apb(1, hcs_pkg::OFS_CMD, 32'hC);
		@(posedge pclk);
		`CHK(hub_reset_pulse, 1'b1)
		apb(1, hcs_pkg::OFS_CMD, 32'hA);
		repeat (2) @(posedge pclk);
		`CHK({special_resume, vendor_hub_commands, hub_reset_pulse}, 3'h6)
		apb(1, hcs_pkg::OFS_CMD, 32'h5A50);
		@(posedge pclk);
		`CHK({pass_valid, pass_op, pass_data}, 11'h55A)
		// Clock enable low must freeze the pin drive
		ce <= 0;
		suspend_state <= 1;
		repeat (3) @(posedge pclk);
		`CHK(strap_out, 16'hA5A5)
		ce <= 1;
		repeat (2) @(posedge pclk);
		`CHK(strap_out, 16'hA5A1)
		apb(1, hcs_pkg::OFS_CTRL, 32'h6FF);
		repeat (2) @(posedge pclk);
		`CHK(otp_mode, 2'h0)
		`CHK(port_charge_report, 4'hF)
		`CHK({charge_up_mode, charge_dn_mode}, 4'h9)
		hub_attached <= 1;
		repeat (2) @(posedge pclk);
		apb(1, hcs_pkg::OFS_FIXED, 32'h0);
		`CHK(e, 1'b1)
		repeat (2) @(posedge pclk);
		`CHK(fixed_ports, 4'hF)
		hub_attached <= 0;
		$display("register test done");
		run_case(0, 2'b00, 2'b00, 3'd0, 4'h0);
		run_case(0, 2'b10, 2'b10, 3'd1, 4'h3);
		run_case(1, 2'b11, 2'b11, 3'd2, 4'h0);
		run_case(1, 2'b01, 2'b11, 3'd3, 4'h0);
		run_case(0, 2'b01, 2'b11, 3'd4, 4'h0);
		print_verdict;
	end
endmodule : hub_config_select_and_straps_tb_top
